/* File: cond_branch_map.vh */
// constants for the conditional branch unit: opcodes, fields, widths
// assumes a 32-bit instruction word and a core-supplied pc and registers
// Contract
// - decode coprocessor branches: opcode, subfield, fields
// - target is delay slot pc plus offset times four
// - false polarity branches when selected bit zero
// - true polarity branches when selected bit one
// - delay slot runs unless a likely form is not taken; redirect comes afterwards
// - likely not taken nullifies the delay slot
// - omitted selector encodes as condition bit zero
// - coprocessor disabled or absent raises exceptions
// - equality branch compares full registers, then redirects
// - likely equality decode; nullify; no exceptions
// - register zero twice means always taken
`ifndef COND_BRANCH_MAP_VH
`define COND_BRANCH_MAP_VH
// ----------------------------------------------------------------
// opcode and field layout
// ----------------------------------------------------------------
`define OPC_HI 31
`define OPC_LO 26
`define OPC_COPROC_TWO 6'h12
`define OPC_BRANCH_IF_EQUAL 6'h04
`define OPC_BRANCH_IF_EQUAL_LIKELY 6'h14
`define SUB_HI 25
`define SUB_LO 21
`define SUB_BRANCH 5'h08
`define SEL_HI 20
`define SEL_LO 18
`define NULLIFY_BIT 17
`define POLARITY_BIT 16
`define OFFSET_HI 15
`define OFFSET_LO 0
`define SRC_A_HI 25
`define SRC_A_LO 21
`define SRC_B_HI 20
`define SRC_B_LO 16
// ----------------------------------------------------------------
// target arithmetic
// ----------------------------------------------------------------
`define OFFSET_SHIFT 2
`define DELAY_SLOT_STEP 3'h4
`endif

/* File: branch_target.v */
// branch target adder: delay slot address plus scaled offset
// assumes pc is the branch's own address, word aligned
`timescale 1ns/1ps
`include "cond_branch_map.vh"
module branch_target #(
  parameter XLEN = 64
) (
  // operands
  input wire [XLEN-1:0] branch_pc_in,
  input wire [15:0] offset_in,
  // result
  output wire [XLEN-1:0] target_out
);
  wire [17:0] shifted;
  wire [XLEN-1:0] ext;
  wire [XLEN-1:0] slot_pc;
  assign shifted = {offset_in, {`OFFSET_SHIFT{1'b0}}};
  // sign extend 18 bits to register width
  assign ext = {{(XLEN-18){shifted[17]}}, shifted};
  // relative to the delay slot, not the branch
  assign slot_pc = branch_pc_in + {{(XLEN-3){1'b0}}, `DELAY_SLOT_STEP};
  assign target_out = slot_pc + ext;
endmodule

/* File: cond_branch_unit.v */
// conditional branch decode and execute for coproc-two and equality
// assumes the core issues one instruction per valid pulse, supplies
// register operands read in the same cycle, and honours the outputs
`timescale 1ns/1ps
`include "cond_branch_map.vh"
module cond_branch_unit #(
  parameter XLEN = 64
) (
  // clock and reset
  input wire ref_clk_in,
  input wire reset_in,
  // issue
  input wire issue_valid_in,
  input wire [31:0] instr_in,
  input wire [XLEN-1:0] pc_in,
  input wire [XLEN-1:0] source_reg_a_in,
  input wire [XLEN-1:0] source_reg_b_in,
  // coprocessor two status
  input wire [7:0] cp2_cond_in,
  input wire cp2_usable_in,
  input wire cp2_present_in,
  // results
  output wire is_branch_out,
  output reg redirect_out,
  output reg [XLEN-1:0] redirect_pc_out,
  output reg nullify_slot_out,
  output reg cp_unusable_exc_out,
  output reg reserved_instr_exc_out
);
  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire [5:0] opc;
  wire is_cp2_br;
  wire is_beq;
  wire is_branch_if_equal_likely;
  wire [2:0] condition_select;
  wire nullify_delay_flag;
  wire polarity_flag;
  wire [XLEN-1:0] target;
  wire sel_bit;
  wire cond_met;
  wire likely;
  wire cp2_exc;
  wire slot_pending;
  assign opc = instr_in[`OPC_HI:`OPC_LO];
  assign is_cp2_br = (opc == `OPC_COPROC_TWO) &&
    (instr_in[`SUB_HI:`SUB_LO] == `SUB_BRANCH);
  assign is_beq = (opc == `OPC_BRANCH_IF_EQUAL);
  assign is_branch_if_equal_likely = (opc == `OPC_BRANCH_IF_EQUAL_LIKELY);
  // the short form encodes selector zero, so no special case
  assign condition_select = instr_in[`SEL_HI:`SEL_LO];
  assign nullify_delay_flag = instr_in[`NULLIFY_BIT];
  assign polarity_flag = instr_in[`POLARITY_BIT];
  assign is_branch_out = issue_valid_in && (is_cp2_br || is_beq || is_branch_if_equal_likely);

  // ----------------------------------------------------------------
  // condition bit selection
  // ----------------------------------------------------------------
  // one-hot select keeps the path a flat and-or, no shifter
  wire [7:0] sel_hot;
  wire [7:0] sel_pick;
  genvar g_sel;
  generate
    for (g_sel = 0; g_sel < 8; g_sel = g_sel + 1) begin : g_cond
      localparam [2:0] SEL_CODE = g_sel;
      assign sel_hot[g_sel] = (condition_select == SEL_CODE);
      assign sel_pick[g_sel] = sel_hot[g_sel] && cp2_cond_in[g_sel];
    end
  endgenerate
  assign sel_bit = |sel_pick;

  // ----------------------------------------------------------------
  // full-width register compare
  // ----------------------------------------------------------------
  // every bit takes part, so r0 against r0 is equal
  wire [XLEN-1:0] same_bit;
  wire regs_equal;

  genvar g_eq;
  generate
    for (g_eq = 0; g_eq < XLEN; g_eq = g_eq + 1) begin : g_cmp
      assign same_bit[g_eq] =
        (source_reg_a_in[g_eq] == source_reg_b_in[g_eq]);
    end
  endgenerate
  // one wide and of the per-bit matches
  assign regs_equal = &same_bit;

  // ----------------------------------------------------------------
  // form code: which of the six branches is issuing
  // ----------------------------------------------------------------
  // codes only name the forms; their values carry no meaning
  localparam [2:0] FORM_NONE = 3'h0;
  localparam [2:0] FORM_CP2_FALSE = 3'h1;
  localparam [2:0] FORM_CP2_FALSE_LIKELY = 3'h2;
  localparam [2:0] FORM_CP2_TRUE = 3'h3;
  localparam [2:0] FORM_CP2_TRUE_LIKELY = 3'h4;
  localparam [2:0] FORM_EQUAL = 3'h5;
  localparam [2:0] FORM_EQUAL_LIKELY = 3'h6;

  reg [2:0] form;
  reg form_cond;
  reg form_likely;

  // nullify and polarity flags pick one of four coprocessor forms
  always @* begin
    form = FORM_NONE;
    if (is_cp2_br && !nullify_delay_flag && !polarity_flag) begin
      form = FORM_CP2_FALSE;
    end else if (is_cp2_br && nullify_delay_flag && !polarity_flag) begin
      form = FORM_CP2_FALSE_LIKELY;
    end else if (is_cp2_br && !nullify_delay_flag) begin
      form = FORM_CP2_TRUE;
    end else if (is_cp2_br) begin
      form = FORM_CP2_TRUE_LIKELY;
    end else if (is_beq) begin
      form = FORM_EQUAL;
    end else if (is_branch_if_equal_likely) begin
      form = FORM_EQUAL_LIKELY;
    end
  end

  // each form names the value that takes it and whether it nullifies
  always @* begin
    form_cond = 1'b0;
    form_likely = 1'b0;
    case (form)
      FORM_CP2_FALSE: begin
        // a zero bit takes the false form
        form_cond = !sel_bit;
      end
      FORM_CP2_FALSE_LIKELY: begin
        form_cond = !sel_bit;
        form_likely = 1'b1;
      end
      FORM_CP2_TRUE: begin
        // a one bit takes the true form
        form_cond = sel_bit;
      end
      FORM_CP2_TRUE_LIKELY: begin
        form_cond = sel_bit;
        form_likely = 1'b1;
      end
      FORM_EQUAL: begin
        form_cond = regs_equal;
      end
      FORM_EQUAL_LIKELY: begin
        form_cond = regs_equal;
        form_likely = 1'b1;
      end
      default: begin
        form_cond = 1'b0;
        form_likely = 1'b0;
      end
    endcase
  end
  assign cond_met = form_cond;
  assign likely = form_likely;

  // ----------------------------------------------------------------
  // exceptions and target
  // ----------------------------------------------------------------
  // equality forms never raise, only the coprocessor form
  assign cp2_exc = is_cp2_br && (!cp2_present_in || !cp2_usable_in);
  branch_target #(
    .XLEN(XLEN)
  ) u_target (
    .branch_pc_in(pc_in),
    .offset_in(instr_in[`OFFSET_HI:`OFFSET_LO]),
    .target_out(target)
  );

  // ----------------------------------------------------------------
  // branch state carried to the delay slot cycle
  // ----------------------------------------------------------------
  // two states: no branch waiting, or a branch waiting for its slot
  localparam [0:0] ST_IDLE = 1'b0;
  localparam [0:0] ST_SLOT = 1'b1;

  reg state_ff;
  reg taken_ff;
  reg likely_ff;
  reg [XLEN-1:0] target_ff;
  reg nxt_state;
  reg nxt_taken;
  reg nxt_likely;
  reg [XLEN-1:0] nxt_target;
  wire fresh_issue;
  wire slot_issue;
  wire accept;

  // an instruction issued while a branch waits is that branch's slot
  assign slot_pending = (state_ff == ST_SLOT);
  assign fresh_issue = issue_valid_in && !slot_pending;
  assign slot_issue = issue_valid_in && slot_pending;
  // a branch that raises is not recorded and never redirects
  assign accept = fresh_issue && is_branch_out && !cp2_exc;

  // condition is sampled in the branch cycle, acted on next
  always @* begin
    nxt_state = state_ff;
    nxt_taken = taken_ff;
    nxt_likely = likely_ff;
    nxt_target = target_ff;
    case (state_ff)
      ST_IDLE: begin
        if (accept) begin
          nxt_state = ST_SLOT;
          nxt_taken = cond_met;
          nxt_likely = likely;
          nxt_target = target;
        end
      end
      ST_SLOT: begin
        // a branch in the slot is left unpredictable by software; the
        // earlier branch wins since its redirect is pending
        if (issue_valid_in) begin
          nxt_state = ST_IDLE;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always @(posedge ref_clk_in) begin
    if (reset_in) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // the payload only matters while a branch waits for its slot
  always @(posedge ref_clk_in) begin
    if (reset_in) begin
      taken_ff <= 1'b0;
      likely_ff <= 1'b0;
      target_ff <= {XLEN{1'b0}};
    end else begin
      taken_ff <= nxt_taken;
      likely_ff <= nxt_likely;
      target_ff <= nxt_target;
    end
  end

  // ----------------------------------------------------------------
  // next values of the result pulses
  // ----------------------------------------------------------------
  // worked out here so that the output flops stay plain
  reg nxt_redirect;
  reg nxt_nullify;
  reg nxt_unusable;
  reg nxt_reserved;

  always @* begin
    nxt_redirect = 1'b0;
    nxt_nullify = 1'b0;
    // redirect only once the slot instruction has issued
    if (slot_issue && taken_ff) begin
      nxt_redirect = 1'b1;
    end else if (slot_issue && likely_ff) begin
      // likely and not taken: the slot must leave no trace
      nxt_nullify = 1'b1;
    end
  end

  // absent wins over disabled; only a real issue can raise
  always @* begin
    nxt_unusable = 1'b0;
    nxt_reserved = 1'b0;
    if (!fresh_issue || !is_cp2_br) begin
      nxt_unusable = 1'b0;
    end else if (!cp2_present_in) begin
      nxt_reserved = 1'b1;
    end else if (!cp2_usable_in) begin
      nxt_unusable = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // outputs, registered one cycle after the slot instruction issues; exceptions one cycle after the branch issues
  // ----------------------------------------------------------------
  always @(posedge ref_clk_in) begin
    if (reset_in) begin
      redirect_out <= 1'b0;
      redirect_pc_out <= {XLEN{1'b0}};
      nullify_slot_out <= 1'b0;
      cp_unusable_exc_out <= 1'b0;
      reserved_instr_exc_out <= 1'b0;
    end else begin
      redirect_out <= nxt_redirect;
      // the target stands until the next taken branch replaces it
      if (nxt_redirect) begin
        redirect_pc_out <= target_ff;
      end
      nullify_slot_out <= nxt_nullify;
      // exceptions come one cycle after the branch edge
      cp_unusable_exc_out <= nxt_unusable;
      reserved_instr_exc_out <= nxt_reserved;
    end
  end
endmodule

/* File: cp2_model.sv */
// coprocessor two model: eight condition bits for the branch unit
// assumes the bench loads new bits only between branches
`timescale 1ns/1ps
module cp2_model (
  input wire ref_clk_in,
  input wire load_in,
  input wire [7:0] value_in,
  output reg [7:0] cond_out
);
  initial cond_out = 8'h00;
  // bits move only on a load, so they stand still while a branch reads them
  always @(posedge ref_clk_in) begin
    if (load_in) cond_out <= value_in;
  end
endmodule

/* File: cbu_asserts.sv */
// port checker for the branch unit
// assumes one clock and a synchronous reset
`timescale 1ns/1ps
module cbu_asserts #(parameter XLEN = 64) (
  input wire ref_clk_in, input wire reset_in, input wire issue_valid_in,
  input wire [31:0] instr_in, input wire [XLEN-1:0] pc_in,
  input wire [XLEN-1:0] source_reg_a_in,
  input wire [XLEN-1:0] source_reg_b_in,
  input wire [7:0] cp2_cond_in, input wire cp2_usable_in,
  input wire cp2_present_in, input wire is_branch_out,
  input wire redirect_out, input wire [XLEN-1:0] redirect_pc_out,
  input wire nullify_slot_out, input wire cp_unusable_exc_out,
  input wire reserved_instr_exc_out);
  wire c2 = issue_valid_in && instr_in[31:21] == {6'h12, 5'h08};
  wire eq = issue_valid_in &&
    (instr_in[31:26] == 6'h04 || instr_in[31:26] == 6'h14);
  wire eql = instr_in[31:26] == 6'h14;
  wire ok = cp2_present_in && cp2_usable_in;
  wire hit = cp2_cond_in[instr_in[20:18]] == instr_in[16];
  wire same = source_reg_a_in == source_reg_b_in;
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);
  decode_all_a: assert property (
    is_branch_out == (c2 || eq)) else $error("bad decode");
  unusable_exc_a: assert property (
    c2 && cp2_present_in && !cp2_usable_in |=> cp_unusable_exc_out)
    else $error("no unusable exc");
  reserved_exc_a: assert property (
    c2 && !cp2_present_in |=> reserved_instr_exc_out && !cp_unusable_exc_out)
    else $error("no reserved exc");
  eq_no_exc_a: assert property (
    eq |=> !cp_unusable_exc_out && !reserved_instr_exc_out)
    else $error("exc on equality");
  cp_taken_a: assert property (
    c2 && ok && hit ##1 issue_valid_in |=> redirect_out && !nullify_slot_out)
    else $error("missed redirect");
  likely_null_a: assert property (
    c2 && ok && !hit && instr_in[17] ##1 issue_valid_in
    |=> nullify_slot_out && !redirect_out) else $error("no nullify");
  plain_slot_a: assert property (
    c2 && ok && !hit && !instr_in[17] ##1 issue_valid_in
    |=> !nullify_slot_out && !redirect_out) else $error("slot squashed");
  eq_taken_a: assert property (
    eq && same ##1 issue_valid_in |=> redirect_out)
    else $error("equal not taken");
  eq_likely_null_a: assert property (
    eq && eql && !same ##1 issue_valid_in
    |=> nullify_slot_out && !redirect_out) else $error("eq no nullify");
  eq_plain_slot_a: assert property (
    eq && !eql && !same ##1 issue_valid_in
    |=> !nullify_slot_out && !redirect_out) else $error("eq slot squashed");
  exc_needs_issue_a: assert property (
    !issue_valid_in |=> !cp_unusable_exc_out && !reserved_instr_exc_out)
    else $error("exc without issue");
endmodule
bind cond_branch_unit cbu_asserts #(.XLEN(XLEN)) chk_i (
  .ref_clk_in(ref_clk_in), .reset_in(reset_in),
  .issue_valid_in(issue_valid_in), .instr_in(instr_in), .pc_in(pc_in),
  .source_reg_a_in(source_reg_a_in), .source_reg_b_in(source_reg_b_in),
  .cp2_cond_in(cp2_cond_in), .cp2_usable_in(cp2_usable_in),
  .cp2_present_in(cp2_present_in), .is_branch_out(is_branch_out),
  .redirect_out(redirect_out), .redirect_pc_out(redirect_pc_out),
  .nullify_slot_out(nullify_slot_out),
  .cp_unusable_exc_out(cp_unusable_exc_out),
  .reserved_instr_exc_out(reserved_instr_exc_out));

/* File: tb_top.sv */
// self-checking bench for the conditional branch unit
// assumes the unit, its checker and the coprocessor model beside it
`timescale 1ns/1ps
module tb_top;
  reg clk = 0, rst = 1, vld = 0, use_ok = 1, pres = 1, ld = 0, hit, nd, xc;
  reg [31:0] ins = 0, r = 32'hf15a;
  reg [63:0] pc = 0, ra = 0, rb = 0, epc = 0, tgt;
  reg [7:0] cv = 0;
  reg [2:0] k;
  reg [63:0] tq [$];
  integer err_total = 0, cmp_count = 0, i;
  wire [7:0] cond;
  wire isb, redir, nul, ue, re;
  wire [63:0] rpc;
  cp2_model cp (.ref_clk_in(clk), .load_in(ld), .value_in(cv),
    .cond_out(cond));
  cond_branch_unit #(.XLEN(64)) dut (.ref_clk_in(clk), .reset_in(rst),
    .issue_valid_in(vld), .instr_in(ins), .pc_in(pc), .source_reg_a_in(ra),
    .source_reg_b_in(rb), .cp2_cond_in(cond), .cp2_usable_in(use_ok),
    .cp2_present_in(pres), .is_branch_out(isb), .redirect_out(redir),
    .redirect_pc_out(rpc), .nullify_slot_out(nul),
    .cp_unusable_exc_out(ue), .reserved_instr_exc_out(re));
  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task chk(input [63:0] seen, input [63:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (seen !== exp) begin
        err_total = err_total + 1;
        $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
      end
    end
  endtask
  task print_verdict;
    begin
      if (err_total == 0 && cmp_count > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  initial forever #5 clk = ~clk;
  initial begin
    #100000;
    err_total = err_total + 1;
    print_verdict;
  end
  // ----------------------------------------
  // each round: load bits, branch, slot, check
  // ----------------------------------------
  initial begin
    repeat (16) @(negedge clk);
    rst = 0;
    chk(rpc, 64'h0);
    for (i = 0; i < 200; i = i + 1) begin
      r = lfsr(r);
      k = r[2:0] % 6;
      pres = r[3] | r[4];
      use_ok = r[5] | r[6];
      // likely forms stay the rarer case, as software is told
      nd = k[0] & r[16];
      cv = r[15:8];
      ld = 1;
      xc = k < 4 && !(pres && use_ok);
      r = lfsr(r);
      ra = r[8] ? 64'h0 : {r, ~r};
      rb = r[7] ? ra : {~r, r};
      hit = k < 4 ? cv[r[20:18]] == k[1] : ra == rb;
      pc = {lfsr(r), r[31:2], 2'b00};
      tgt = pc + 4 + {{46{r[15]}}, r[15:0], 2'b00};
      if (!xc && hit) tq.push_back(tgt);
      @(negedge clk);
      ld = 0;
      vld = 1;
      ins = k < 4 ? {6'h12, 5'h08, r[20:18], nd, k[1], r[15:0]}
                  : {nd ? 6'h14 : 6'h04, r[25:0]};
      @(negedge clk);
      chk(isb, 1);
      chk(ue, k < 4 && pres && !use_ok);
      chk(re, k < 4 && !pres);
      // the slot is never a branch, a jump or a return
      ins = 32'h0;
      pc = pc + 4;
      @(negedge clk);
      vld = 0;
      if (!xc && hit && tq.size() > 0) epc = tq.pop_front();
      chk(redir, !xc && hit);
      chk(nul, !xc && !hit && nd);
      chk(rpc, epc);
    end
    print_verdict;
  end
endmodule
